// ---- rmc_consts.svh ----
// Constants shared by the radio mode controller ends
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH
`define RMC_CLK_MHZ 125
// Device-side serial register map, command byte bit 7 marks a write
`define RMC_CMD_WR_BIT 7
`define RMC_REG_CONFIG 7'h00
`define RMC_REG_SETUP 7'h01
`define RMC_REG_STATUS 7'h02
`define RMC_REG_TXPL 7'h03
`define RMC_REG_RXPL 7'h04
`define RMC_CFG_PRIMARY_RECEIVE_SELECT 0
`define RMC_CFG_POWER_UP_BIT 1
`define RMC_SETUP_RATE 3
`define RMC_FIFO_DEPTH 3
// Timing figures in ns; RMC_POR_CYCLES and RMC_SCK_HALF in clock cycles
`define RMC_T_SETTLE_NS 130000
`define RMC_T_CD_NS 128000
`define RMC_T_CE_MIN_NS 10000
`define RMC_T_CE_PULSE_NS 12000
`define RMC_T_CE2CSN_NS 4000
`define RMC_T_PD_XTAL_NS 1500000
`define RMC_T_PD_EXT_NS 150000
`define RMC_T_TX_MAX_NS 4000000
`define RMC_POR_CYCLES 16
`define RMC_SCK_HALF 10
// Controller AXI4-Lite map
`define RMC_AXI_CTRL 8'h00
`define RMC_AXI_CMD 8'h04
`define RMC_AXI_STATUS 8'h08
`define RMC_CTRL_CE 0
`define RMC_CTRL_PULSE 1
`define RMC_CTRL_EXTCLK 2
`endif

// ---- rmc_pkg.sv ----
// Types of the radio mode controller
package rmc_pkg;
`include "rmc_consts.svh"
    typedef enum logic [2:0] {
        RMC_POR, RMC_PDN, RMC_STBY1, RMC_STBY2, RMC_SET_TX, RMC_SET_RX, RMC_TX, RMC_RX
    } rmc_mode_t;
    typedef enum logic [1:0] {RMC_H_IDLE, RMC_H_WAIT, RMC_H_SHIFT, RMC_H_END} rmc_spi_t;
    typedef logic [`RMC_FIFO_DEPTH-1:0][7:0] rmc_fifo_t;
    typedef struct packed {
        rmc_mode_t mode;
        logic [15:0] por_cnt;
        logic [15:0] tmr;
        logic [15:0] ce_cnt;
        logic [15:0] cd_cnt;
        logic [2:0] sck_s;
        logic [2:0] csn_s;
        logic [1:0] mosi_s;
        logic [1:0] ce_s;
        logic [4:0] bitc;
        logic [7:0] sh_in;
        logic [7:0] cmd;
        logic [7:0] sh_out;
        logic tx_pend;
        logic [7:0] tx_stage;
        logic power_up_bit;
        logic primary_receive_select;
        logic air_rate;
        rmc_fifo_t txq;
        logic [1:0] tx_n;
        rmc_fifo_t rxq;
        logic [1:0] rx_n;
        logic cd;
        logic miso;
        logic miso_oe;
        logic tx_go;
        logic [7:0] tx_byte;
        logic rx_drop;
    } rmc_dev_st_t;
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ce_level;
        logic ext_clk;
        logic [15:0] pulse_cnt;
        logic ce_q;
        logic [15:0] ce_age;
        logic pwr_on;
        logic primary_receive_select;
        logic cfg_done;
        logic [17:0] pd_cnt;
        logic [19:0] tx_cnt;
        logic tx_lim;
        rmc_spi_t spi;
        logic [15:0] sh;
        logic [15:0] rxsh;
        logic [4:0] bitn;
        logic [7:0] div;
        logic sck;
        logic csn;
        logic mosi;
        logic [1:0] miso_s;
        logic [7:0] rbyte;
    } rmc_host_st_t;
endpackage : rmc_pkg

// ---- rmc_link_if.sv ----
// Serial and chip-enable link between controller and radio device
`timescale 1ns/10ps
interface rmc_link_if;
    logic ce;
    logic csn;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;
    // Undriven data line reads low
    assign miso = miso_oe & miso_o;
    modport dev (input ce, input csn, input sck, input mosi, output miso_o, output miso_oe);
    modport host (output ce, output csn, output sck, output mosi, input miso);
endinterface : rmc_link_if

// ---- rmc_device.sv ----
// Radio device end: operating-mode state machine with serial register access
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "rmc_consts.svh"
module rmc_device
    import rmc_pkg::*;
#(
    parameter int SETTLE_CYCLES = (`RMC_T_SETTLE_NS * `RMC_CLK_MHZ) / 1000,
    parameter int CD_CYCLES = (`RMC_T_CD_NS * `RMC_CLK_MHZ + 999) / 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    rmc_link_if.dev lnk,
    input wire logic rf_pkt_valid,
    input wire logic rf_addr_match,
    input wire logic rf_crc_ok,
    input wire logic [7:0] rf_pkt_byte,
    input wire logic rf_signal,
    input wire logic tx_done,
    output rmc_mode_t mode,
    output logic tx_go,
    output logic [7:0] tx_byte,
    output logic carrier_detect_flag,
    output logic air_rate_2m,
    output logic rx_drop
);
    localparam int CE_MIN_CYCLES = (`RMC_T_CE_MIN_NS * `RMC_CLK_MHZ + 999) / 1000;
    localparam logic [1:0] DEPTH = 2'(`RMC_FIFO_DEPTH);

    rmc_dev_st_t q;
    rmc_dev_st_t d;

    always_comb begin
        logic sck_rise;
        logic sck_fall;
        logic csn_low;
        logic csn_rise;
        logic ce;
        logic [7:0] byte_in;
        logic pop_tx;
        logic push_tx;
        logic pop_rx;
        logic push_rx;
        sck_rise = q.sck_s[1] & ~q.sck_s[2];
        sck_fall = ~q.sck_s[1] & q.sck_s[2];
        csn_low = ~q.csn_s[1];
        csn_rise = q.csn_s[1] & ~q.csn_s[2];
        ce = q.ce_s[1];
        byte_in = {q.sh_in[6:0], q.mosi_s[1]};
        pop_tx = 1'b0;
        push_tx = 1'b0;
        pop_rx = 1'b0;
        push_rx = 1'b0;
        d = q;
        d.tx_go = 1'b0;
        d.rx_drop = 1'b0;
        d.sck_s = {q.sck_s[1:0], lnk.sck};
        d.csn_s = {q.csn_s[1:0], lnk.csn};
        d.mosi_s = {q.mosi_s[0], lnk.mosi};
        d.ce_s = {q.ce_s[0], lnk.ce};
        d.miso_oe = csn_low;
        // Serial slave stays live in every mode
        if (!csn_low) begin
            d.bitc = 5'h00;
        end else if (sck_rise) begin
            d.sh_in = byte_in;
            d.bitc = q.bitc + 5'h01;
            if (q.bitc == 5'h07) begin
                d.cmd = byte_in;
                unique case (byte_in[6:0])
                    `RMC_REG_CONFIG: begin
                        d.sh_out = 8'h00;
                        d.sh_out[`RMC_CFG_POWER_UP_BIT] = q.power_up_bit;
                        d.sh_out[`RMC_CFG_PRIMARY_RECEIVE_SELECT] = q.primary_receive_select;
                    end
                    `RMC_REG_SETUP: begin
                        d.sh_out = 8'h00;
                        d.sh_out[`RMC_SETUP_RATE] = q.air_rate;
                    end
                    `RMC_REG_STATUS: d.sh_out = {q.rx_n, q.tx_n, q.cd, 3'(q.mode)};
                    `RMC_REG_RXPL: begin
                        d.sh_out = q.rxq[0];
                        pop_rx = !byte_in[`RMC_CMD_WR_BIT] && q.rx_n != 2'h0;
                    end
                    default: d.sh_out = 8'h00;
                endcase
            end else if (q.bitc == 5'h0f && q.cmd[`RMC_CMD_WR_BIT]) begin
                unique case (q.cmd[6:0])
                    `RMC_REG_CONFIG: begin
                        d.power_up_bit = byte_in[`RMC_CFG_POWER_UP_BIT];
                        d.primary_receive_select = byte_in[`RMC_CFG_PRIMARY_RECEIVE_SELECT];
                    end
                    `RMC_REG_SETUP: d.air_rate = byte_in[`RMC_SETUP_RATE];
                    `RMC_REG_TXPL: begin
                        d.tx_pend = 1'b1;
                        d.tx_stage = byte_in;
                    end
                    default: ;
                endcase
            end
        end
        if (csn_low && sck_fall) begin
            d.miso = q.sh_out[7];
            d.sh_out = {q.sh_out[6:0], 1'b0};
        end
        // Upload commits at chip-select release
        if (csn_rise && q.tx_pend) begin
            d.tx_pend = 1'b0;
            push_tx = q.tx_n != DEPTH;
        end
        d.ce_cnt = ce ? ((q.ce_cnt == 16'(CE_MIN_CYCLES)) ? q.ce_cnt : q.ce_cnt + 16'h1) : 16'h0;
        // Filtered carrier detect
        if (q.mode == RMC_RX && rf_signal) begin
            d.cd_cnt = (q.cd_cnt == 16'(CD_CYCLES)) ? q.cd_cnt : q.cd_cnt + 16'h1;
        end else begin
            d.cd_cnt = 16'h0;
        end
        d.cd = d.cd_cnt == 16'(CD_CYCLES);
        if (q.mode == RMC_RX && rf_pkt_valid && rf_addr_match && rf_crc_ok) begin
            push_rx = q.rx_n != DEPTH;
            d.rx_drop = q.rx_n == DEPTH;
        end
        unique case (q.mode)
            RMC_POR: begin
                d.por_cnt = q.por_cnt + 16'h1;
                if (q.por_cnt == 16'(`RMC_POR_CYCLES - 1)) d.mode = RMC_PDN;
            end
            RMC_PDN: if (q.power_up_bit) d.mode = RMC_STBY1;
            RMC_STBY1: begin
                if (ce && q.primary_receive_select) begin
                    d.mode = RMC_SET_RX;
                end else if (ce && q.tx_n == 2'h0) begin
                    d.mode = RMC_STBY2;
                end else if (ce && q.ce_cnt == 16'(CE_MIN_CYCLES)) begin
                    d.mode = RMC_SET_TX;
                end
            end
            RMC_STBY2: begin
                if (!ce) d.mode = RMC_STBY1;
                else if (q.primary_receive_select) d.mode = RMC_SET_RX;
                else if (q.tx_n != 2'h0) d.mode = RMC_SET_TX;
            end
            RMC_SET_TX, RMC_SET_RX: begin
                d.tmr = q.tmr + 16'h1;
                if (q.mode == RMC_SET_RX && !ce) begin
                    d.mode = RMC_STBY1;
                    d.tmr = 16'h0;
                end else if (q.tmr == 16'(SETTLE_CYCLES - 1)) begin
                    d.tmr = 16'h0;
                    d.mode = (q.mode == RMC_SET_TX) ? RMC_TX : RMC_RX;
                    d.tx_go = q.mode == RMC_SET_TX;
                    d.tx_byte = q.txq[0];
                end
            end
            RMC_TX: begin
                if (tx_done) begin
                    pop_tx = 1'b1;
                    if (!ce) begin
                        d.mode = RMC_STBY1;
                    end else if (q.primary_receive_select) begin
                        d.mode = RMC_SET_RX;
                    end else if (q.tx_n > 2'h1) begin
                        d.tx_go = 1'b1;
                        d.tx_byte = q.txq[1];
                    end else begin
                        d.mode = RMC_STBY2;
                    end
                end
            end
            RMC_RX: if (!ce) d.mode = RMC_STBY1;
        endcase
        if (!q.power_up_bit && q.mode != RMC_POR) begin
            d.mode = RMC_PDN;
            d.tmr = 16'h0;
        end
        // FIFO update: pop shifts down, push lands behind the last entry
        if (pop_tx) begin
            d.txq = {8'h00, q.txq[`RMC_FIFO_DEPTH-1:1]};
            d.tx_n = q.tx_n - 2'h1;
        end
        if (push_tx) begin
            d.txq[d.tx_n] = q.tx_stage;
            d.tx_n = d.tx_n + 2'h1;
        end
        if (pop_rx) begin
            d.rxq = {8'h00, q.rxq[`RMC_FIFO_DEPTH-1:1]};
            d.rx_n = q.rx_n - 2'h1;
        end
        if (push_rx) begin
            d.rxq[d.rx_n] = rf_pkt_byte;
            d.rx_n = d.rx_n + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mode <= RMC_POR;
            q.sck_s <= 3'h0;
            q.csn_s <= 3'h7;
            q.ce_s <= 2'h0;
        end else begin
            q <= d;
        end
    end

    assign lnk.miso_o = q.miso;
    assign lnk.miso_oe = q.miso_oe;
    assign mode = q.mode;
    assign tx_go = q.tx_go;
    assign tx_byte = q.tx_byte;
    assign carrier_detect_flag = q.cd;
    assign air_rate_2m = q.air_rate;
    assign rx_drop = q.rx_drop;
endmodule : rmc_device

// ---- rmc_host.sv ----
// Controller end: AXI4-Lite registers driving the serial link and activate pin
`timescale 1ns/10ps
`include "rmc_consts.svh"
module rmc_host
    import rmc_pkg::*;
#(
    parameter int PD_XTAL_CYCLES = (`RMC_T_PD_XTAL_NS * `RMC_CLK_MHZ + 999) / 1000,
    parameter int PD_EXT_CYCLES = (`RMC_T_PD_EXT_NS * `RMC_CLK_MHZ + 999) / 1000,
    parameter int TX_MAX_CYCLES = (`RMC_T_TX_MAX_NS * `RMC_CLK_MHZ) / 1000,
    parameter int SCK_HALF = `RMC_SCK_HALF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    rmc_link_if.host lnk
);
    localparam int PULSE_CYCLES = (`RMC_T_CE_PULSE_NS * `RMC_CLK_MHZ + 999) / 1000;
    localparam int CE2CSN_CYCLES = (`RMC_T_CE2CSN_NS * `RMC_CLK_MHZ + 999) / 1000;

    rmc_host_st_t q;
    rmc_host_st_t d;
    logic ce_out;
    logic ready;

    assign ready = q.pwr_on && q.cfg_done
        && q.pd_cnt == 18'(q.ext_clk ? PD_EXT_CYCLES : PD_XTAL_CYCLES);
    assign ce_out = ready && !q.tx_lim && (q.ce_level || q.pulse_cnt != 16'h0);

    always_comb begin
        logic tick;
        tick = q.div == 8'(SCK_HALF - 1);
        d = q;
        d.ce_q = ce_out;
        d.miso_s = {q.miso_s[0], lnk.miso};
        if (q.pulse_cnt != 16'h0) d.pulse_cnt = q.pulse_cnt - 16'h1;
        d.ce_age = (ce_out && !q.ce_q) ? 16'h0
            : (q.ce_age == 16'(CE2CSN_CYCLES) ? q.ce_age : q.ce_age + 16'h1);
        // Settling counts only once the power-up transfer has reached the device
        if (q.pwr_on && q.spi == RMC_H_IDLE
            && d.pd_cnt != 18'(q.ext_clk ? PD_EXT_CYCLES : PD_XTAL_CYCLES)) begin
            d.pd_cnt = q.pd_cnt + 18'h1;
        end
        // Open-loop transmit guard
        if (ce_out && !q.primary_receive_select) begin
            d.tx_cnt = q.tx_cnt + 20'h1;
            if (q.tx_cnt == 20'(TX_MAX_CYCLES - 1)) d.tx_lim = 1'b1;
        end else begin
            d.tx_cnt = 20'h0;
        end
        if (!q.ce_level && q.pulse_cnt == 16'h0) d.tx_lim = 1'b0;
        // AXI4-Lite slave
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) d.bvalid = 1'b0;
        if (q.aw_full && q.w_full && !q.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            unique case ({q.aw_addr[7:2], 2'b00})
                `RMC_AXI_CTRL: if (q.wstrb[0]) begin
                    d.ce_level = q.wdata[`RMC_CTRL_CE];
                    d.ext_clk = q.wdata[`RMC_CTRL_EXTCLK];
                    if (q.wdata[`RMC_CTRL_PULSE]) d.pulse_cnt = 16'(PULSE_CYCLES);
                end
                `RMC_AXI_CMD: if (q.wstrb[1:0] == 2'b11 && q.spi == RMC_H_IDLE) begin
                    d.sh = q.wdata[15:0];
                    d.spi = RMC_H_WAIT;
                end
                `RMC_AXI_STATUS: ;
                default: d.bresp = 2'b10;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) d.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = 2'b00;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `RMC_AXI_CTRL: d.rdata = {29'h0, q.ext_clk, q.pulse_cnt != 16'h0, q.ce_level};
                `RMC_AXI_CMD: d.rdata = {16'h0, q.sh};
                `RMC_AXI_STATUS: d.rdata = {16'h0, q.rbyte, 4'h0, q.tx_lim, ready, ce_out,
                    q.spi != RMC_H_IDLE};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = 2'b10;
                end
            endcase
        end
        // Serial master, clock made by a divider
        unique case (q.spi)
            RMC_H_IDLE: d.div = 8'h0;
            RMC_H_WAIT: if (!(ce_out && (!q.ce_q || q.ce_age != 16'(CE2CSN_CYCLES)))) begin
                d.csn = 1'b0;
                d.mosi = q.sh[15];
                d.bitn = 5'h0;
                d.div = 8'h0;
                d.spi = RMC_H_SHIFT;
            end
            RMC_H_SHIFT: begin
                d.div = tick ? 8'h0 : q.div + 8'h1;
                if (tick && !q.sck) begin
                    d.sck = 1'b1;
                    d.rxsh = {q.rxsh[14:0], q.miso_s[1]};
                end else if (tick) begin
                    d.sck = 1'b0;
                    d.sh = {q.sh[14:0], 1'b0};
                    d.mosi = q.sh[14];
                    d.bitn = q.bitn + 5'h1;
                    if (q.bitn == 5'h0f) d.spi = RMC_H_END;
                end
            end
            RMC_H_END: begin
                d.div = tick ? 8'h0 : q.div + 8'h1;
                if (tick) begin
                    d.csn = 1'b1;
                    d.mosi = 1'b0;
                    d.rbyte = q.rxsh[7:0];
                    d.spi = RMC_H_IDLE;
                end
            end
        endcase
        if (q.spi == RMC_H_WAIT && d.spi == RMC_H_SHIFT
            && q.sh[15:8] == {1'b1, `RMC_REG_CONFIG}) begin
            d.cfg_done = 1'b1;
            d.primary_receive_select = q.sh[`RMC_CFG_PRIMARY_RECEIVE_SELECT];
            d.pwr_on = q.sh[`RMC_CFG_POWER_UP_BIT];
            if (!q.pwr_on || !q.sh[`RMC_CFG_POWER_UP_BIT]) d.pd_cnt = 18'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.spi <= RMC_H_IDLE;
            q.csn <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_full && !q.bvalid;
    assign s_axi_wready = !q.w_full && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign lnk.ce = q.ce_q;
    assign lnk.csn = q.csn;
    assign lnk.sck = q.sck;
    assign lnk.mosi = q.mosi;
endmodule : rmc_host

// ---- rmc_link_chk.sv ----
// Assertions on the link between the two ends and on the device mode outputs
`timescale 1ns/10ps
module rmc_link_chk
    import rmc_pkg::*;
#(
    parameter int SETTLE = 20,
    parameter int CD = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic csn,
    input wire rmc_mode_t mode,
    input wire logic tx_go,
    input wire logic carrier_detect_flag,
    input wire logic rf_signal,
    input wire logic rx_drop
);
    localparam int S_LO = SETTLE - 2;
    localparam int S_HI = SETTLE + 3;
    localparam int CD_LO = CD - 1;
    logic [15:0] ce_age_q;
    logic [15:0] sig_cnt_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles of activate high, and of unbroken in-channel signal
    always_ff @(posedge aclk) begin
        if (!aresetn || !ce) begin
            ce_age_q <= '0;
        end else if (ce_age_q != 16'hffff) begin
            ce_age_q <= ce_age_q + 16'd1;
        end
        if (!aresetn || !rf_signal) begin
            sig_cnt_q <= '0;
        end else if (sig_cnt_q != 16'hffff) begin
            sig_cnt_q <= sig_cnt_q + 16'd1;
        end
    end
    sequence tx_settled;
        ##[S_LO:S_HI] mode == RMC_TX;
    endsequence
    sequence rx_settled;
        ##[S_LO:S_HI] mode == RMC_RX;
    endsequence
    chk_por_exit: assert property ($past(mode) == RMC_POR && mode != RMC_POR |-> mode == RMC_PDN)
        else $error("power-on reset left to a mode other than power down");
    chk_por_length: assert property ($rose(aresetn) |-> (mode == RMC_POR) [*8] ##[6:10] mode == RMC_PDN)
        else $error("power-on reset length wrong");
    chk_tx_settle: assert property ($rose(mode == RMC_SET_TX) |-> tx_settled)
        else $error("transmit settling not completed in time");
    chk_rx_settle: assert property ($rose(mode == RMC_SET_RX) |-> rx_settled)
        else $error("receive settling not completed in time");
    chk_tx_start: assert property ($rose(mode == RMC_TX) |-> ##[0:1] tx_go)
        else $error("transmit entered without a send start");
    chk_rx_exit: assert property ($past(mode) == RMC_RX && mode != RMC_RX
        |-> mode inside {RMC_STBY1, RMC_PDN})
        else $error("receive left to a wrong mode");
    chk_cd_filter: assert property ($rose(carrier_detect_flag)
        |-> int'(sig_cnt_q) >= CD_LO && mode == RMC_RX)
        else $error("carrier flag rose too early or outside receive");
    chk_ce_to_csn: assert property ($fell(csn) && ce |-> ce_age_q >= 16'd499)
        else $error("select fell too soon after activate rise");
    chk_drop_mode: assert property (rx_drop |-> $past(mode) == RMC_RX)
        else $error("packet drop reported outside receive");
endmodule : rmc_link_chk

// ---- radio_mode_controller_bench.sv ----
// Self-checking bench joining controller and device over the link
`timescale 1ns/10ps
`define check_eq(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module radio_mode_controller_bench;
    import rmc_pkg::*;
    localparam int SETTLE = 20;
    localparam int CD = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0, rf_pkt_byte = '0, tx_byte;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic rf_pkt_valid = 0, rf_addr_match = 0, rf_crc_ok = 0, rf_signal = 0, tx_done = 0;
    logic tx_go, carrier_detect_flag, air_rate_2m, rx_drop;
    rmc_mode_t mode;
    int err_count = 0;
    int n_compared = 0;
    always #4 aclk = ~aclk;
    rmc_link_if rmc_link_if_inst ();
    rmc_device #(.SETTLE_CYCLES(SETTLE), .CD_CYCLES(CD)) rmc_device_inst (.aclk(aclk),
        .aresetn(aresetn), .lnk(rmc_link_if_inst), .rf_pkt_valid(rf_pkt_valid),
        .rf_addr_match(rf_addr_match), .rf_crc_ok(rf_crc_ok), .rf_pkt_byte(rf_pkt_byte),
        .rf_signal(rf_signal), .tx_done(tx_done), .mode(mode), .tx_go(tx_go), .tx_byte(tx_byte),
        .carrier_detect_flag(carrier_detect_flag), .air_rate_2m(air_rate_2m), .rx_drop(rx_drop));
    rmc_host #(.PD_XTAL_CYCLES(50), .PD_EXT_CYCLES(30), .TX_MAX_CYCLES(4000)) rmc_host_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lnk(rmc_link_if_inst));
    rmc_link_chk #(.SETTLE(SETTLE), .CD(CD)) rmc_link_chk_inst (.aclk(aclk), .aresetn(aresetn),
        .ce(rmc_link_if_inst.ce), .csn(rmc_link_if_inst.csn), .mode(mode), .tx_go(tx_go),
        .carrier_detect_flag(carrier_detect_flag), .rf_signal(rf_signal), .rx_drop(rx_drop));
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        `check_eq("bresp", 2'b00, bresp)
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Read controller status until one bit reaches a level
    task automatic poll(input int b, input logic v);
        logic [31:0] d;
        logic [1:0] r;
        do rd(8'h08, d, r); while (d[b] !== v);
    endtask : poll
    task automatic spi(input logic [7:0] c, input logic [7:0] v);
        wr(8'h04, {16'h0, c, v});
        repeat (4) @(posedge aclk);
        poll(0, 1'b0);
    endtask : spi
    task automatic wait_mode(input rmc_mode_t m);
        int n = 0;
        while (mode !== m && n < 5000) begin
            @(posedge aclk);
            n++;
        end
        `check_eq("mode", m, mode)
    endtask : wait_mode
    task automatic wait_go(input logic [7:0] b);
        int n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (tx_go !== 1'b1 && n < 5000);
        `check_eq("tx_byte", b, tx_byte)
    endtask : wait_go
    task automatic done();
        repeat (4) @(posedge aclk);
        tx_done <= 1'b1;
        @(posedge aclk);
        tx_done <= 1'b0;
    endtask : done
    task automatic sig(input int n, input logic e);
        @(posedge aclk);
        rf_signal <= 1'b1;
        repeat (n) @(posedge aclk);
        `check_eq("carrier", e, carrier_detect_flag)
        rf_signal <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : sig
    task automatic pkt(input logic [7:0] b, input logic m, input logic c, input logic drop);
        logic seen;
        seen = 1'b0;
        @(posedge aclk);
        rf_pkt_byte <= b;
        rf_addr_match <= m;
        rf_crc_ok <= c;
        rf_pkt_valid <= 1'b1;
        @(posedge aclk);
        rf_pkt_valid <= 1'b0;
        repeat (3) begin
            @(posedge aclk);
            seen = seen | (rx_drop === 1'b1);
        end
        `check_eq("rx_drop", drop, seen)
    endtask : pkt
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wait_mode(RMC_PDN);
        rd(8'h40, d, r);
        `check_eq("unmapped resp", 2'b10, r)
        spi(8'h81, 8'h08);
        `check_eq("air rate", 1'b1, air_rate_2m)
        spi(8'h01, 8'h00);
        rd(8'h08, d, r);
        `check_eq("setup readback", 8'h08, d[15:8])
        spi(8'h80, 8'h02);
        wait_mode(RMC_STBY1);
        poll(2, 1'b1);
        spi(8'h83, 8'ha5);
        wr(8'h00, 32'h2);
        wait_go(8'ha5);
        while (rmc_link_if_inst.ce !== 1'b0) @(posedge aclk);
        done();
        wait_mode(RMC_STBY1);
        spi(8'h83, 8'h11);
        spi(8'h83, 8'h22);
        wr(8'h00, 32'h1);
        wait_go(8'h11);
        done();
        wait_go(8'h22);
        `check_eq("mode", RMC_TX, mode)
        done();
        wait_mode(RMC_STBY2);
        spi(8'h83, 8'h33);
        wait_go(8'h33);
        done();
        poll(3, 1'b1);
        wait_mode(RMC_STBY1);
        wr(8'h00, 32'h0);
        spi(8'h80, 8'h03);
        poll(2, 1'b1);
        wr(8'h00, 32'h1);
        wait_mode(RMC_RX);
        sig(5, 1'b0);
        sig(CD + 10, 1'b1);
        pkt(8'ha1, 1'b1, 1'b1, 1'b0);
        pkt(8'hb2, 1'b1, 1'b0, 1'b0);
        pkt(8'hc3, 1'b0, 1'b1, 1'b0);
        pkt(8'hd4, 1'b1, 1'b1, 1'b0);
        pkt(8'he5, 1'b1, 1'b1, 1'b0);
        pkt(8'hf6, 1'b1, 1'b1, 1'b1);
        spi(8'h02, 8'h00);
        rd(8'h08, d, r);
        `check_eq("device status", {2'd3, 2'd0, 1'b0, RMC_RX}, d[15:8])
        spi(8'h04, 8'h00);
        rd(8'h08, d, r);
        `check_eq("rx payload", 8'ha1, d[15:8])
        wait_mode(RMC_RX);
        wr(8'h00, 32'h0);
        wait_mode(RMC_STBY1);
        spi(8'h80, 8'h01);
        wait_mode(RMC_PDN);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        err_count++;
        $display("ERROR watchdog expected completion seen timeout");
        end_sim();
    end
endmodule : radio_mode_controller_bench
